// *** rtl/eic_pkg.sv ***
package eic_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address on the bus is four times these)
  // ----------------------------------------------------------------
  localparam logic [7:0] EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL  = 8'h88;
  localparam logic [7:0] EIC_IDX_SER1_EN    = 8'h9a;
  localparam logic [7:0] EIC_IDX_EN_MAIN    = 8'ha8;
  localparam logic [7:0] EIC_IDX_EN_EXT     = 8'hb8;
  localparam logic [7:0] EIC_IDX_REQ_FLAGS  = 8'hc0;
  localparam logic [7:0] EIC_IDX_EDGE_SEL   = 8'hc8;
  localparam logic [7:0] EIC_IDX_USR_POL    = 8'he0;
  localparam logic [7:0] EIC_IDX_USR_PRIO   = 8'he1;
  localparam logic [7:0] EIC_IDX_USR_EN     = 8'he2;
  localparam logic [7:0] EIC_IDX_SRC4_MASK  = 8'he4;
  localparam logic [7:0] EIC_IDX_SRC4_FLAG  = 8'he5;
  localparam logic [7:0] EIC_IDX_SRC5_MASK  = 8'he6;
  localparam logic [7:0] EIC_IDX_SRC5_FLAG  = 8'he7;
  localparam logic [7:0] EIC_IDX_SRC6_MASK  = 8'he8;
  localparam logic [7:0] EIC_IDX_SRC6_FLAG  = 8'he9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] EIC_RST_BYTE       = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EIC_TC_TYPE0   = 0;
  localparam int EIC_TC_FLAG0   = 1;
  localparam int EIC_TC_TYPE1   = 2;
  localparam int EIC_TC_FLAG1   = 3;
  localparam int EIC_SER1_EN_B  = 0;
  localparam int EIC_EN0_B      = 0;
  localparam int EIC_EN1_B      = 2;
  localparam int EIC_GLOBAL_B   = 7;
  localparam int EIC_POL2_B     = 5;
  localparam int EIC_POL3_B     = 6;
  localparam int EIC_FLAG2_B    = 1;
  localparam int EIC_FLAG3_B    = 2;

  // Writable bit masks; bits outside read as zero
  localparam logic [7:0] EIC_WM_SER1_EN   = 8'h01;
  localparam logic [7:0] EIC_WM_EN_MAIN   = 8'hdf;
  localparam logic [7:0] EIC_WM_EN_EXT    = 8'h7e;
  localparam logic [7:0] EIC_WM_REQ_FLAGS = 8'h3e;
  localparam logic [7:0] EIC_WM_EDGE_SEL  = 8'h60;

  // Number of request lines and user pins
  localparam int EIC_LINES      = 7;
  localparam int EIC_USR_PINS   = 8;

endpackage : eic_pkg

// *** rtl/eic_src_bank.sv ***
`timescale 1ns/1ps
module eic_src_bank
  import eic_pkg::*;
#(
  parameter int SRC_N = 4
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [SRC_N-1:0] src_in,
  eic_src_if.bank               bus
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (SRC_N < 1 || SRC_N > 8) begin : g_bad_n
    $error("eic_src_bank: SRC_N must be 1 to 8");
  end

  typedef struct packed {
    logic [SRC_N-1:0] prev;
    logic [SRC_N-1:0] flag;
    logic [SRC_N-1:0] mask;
    logic             any_prev;
  } eic_bank_s;

  eic_bank_s st_q;
  eic_bank_s st_d;
  logic [SRC_N-1:0] rise;
  logic             any;

  // ----------------------------------------------------------------
  // Per-source flags, masks and the OR into one line
  // ----------------------------------------------------------------
  // Each source is caught on its own rising edge so it can be identified
  always_comb begin
    st_d     = st_q;
    rise     = src_in & ~st_q.prev;
    st_d.prev = src_in;
    if (bus.rd_clear) begin
      st_d.flag = st_q.flag & ~bus.clear_bits[SRC_N-1:0];
    end
    st_d.flag = st_d.flag | rise;
    if (bus.mask_we) begin
      st_d.mask = bus.wdata[SRC_N-1:0];
    end
    any           = |(st_q.flag & st_q.mask);
    st_d.any_prev = any;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Level of the OR is turned into a one-cycle rising-edge event
  assign bus.line_evt = any & ~st_q.any_prev;
  assign bus.mask     = 8'(st_q.mask);
  assign bus.flags    = 8'(st_q.flag);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_line_rising: assert property (@(posedge clk_in) disable iff (reset_in)
    bus.line_evt |=> !bus.line_evt)
    else $error("line event lasted more than one cycle");

  chk_mask_gates: assert property (@(posedge clk_in) disable iff (reset_in)
    bus.line_evt |-> ((st_q.flag & st_q.mask) != '0) && !$past(any))
    else $error("line event without a masked-in source flag");

  chk_read_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    bus.rd_clear |=> ((st_q.flag & $past(bus.clear_bits[SRC_N-1:0] & ~rise)) == '0))
    else $error("flag survived the read that returned it");

endmodule : eic_src_bank

// *** rtl/eic_src_if.sv ***
`timescale 1ns/1ps
// Link between the register front end and one multi-source bank
interface eic_src_if;
  logic       mask_we;
  logic [7:0] wdata;
  logic       rd_clear;
  logic [7:0] clear_bits;
  logic [7:0] mask;
  logic [7:0] flags;
  logic       line_evt;

  modport ctrl (output mask_we, output wdata, output rd_clear, output clear_bits,
                input mask, input flags, input line_evt);
  modport bank (input mask_we, input wdata, input rd_clear, input clear_bits,
                output mask, output flags, output line_evt);
endinterface : eic_src_if

// *** rtl/eic_top.sv ***
// Functional notes
// - Bit 0 of serial1 enable register gates the serial channel 1 request.
// - Edge mode: falling edge on line 0 or 1 sets its flag; service clears.
// - Type bits choose falling edge (1) or low level (0) for lines 0/1.
// - Edge-select bit 6 picks line 3 polarity: 0 falling, 1 rising.
// - Edge-select bit 5 picks line 2 polarity: 0 falling, 1 rising.
// - Request-flag register bits 1..5 hold lines 2..6; bits 0,6,7 read zero.
// - Multi-source lines OR sources, each with its own mask and flag.
// - Lines 0/1 come from eight user pins; high/low priority, per-pin polarity.
// - Lines 2/3 each come from a dedicated pin with selectable edge.
// - Lines 4,5,6 collect smart card, USB/RTC/keypad, I2C/fault/comparator.
// - Peripheral sources of lines 4..6 are turned into rising edges.
// - A line reaches the CPU only when enabled; flag is kept regardless.
// - Hardware sets flags on request and clears them when service starts; level-mode lines 0/1 follow the pin.
// - Reading a multi-source flag register clears the flags it returned.
// - Main enable: bit 0 line 0, bit 2 line 1, bit 7 global enable.
// - Extended enable bits 1..5 enable lines 2..6.
`timescale 1ns/1ps
module eic_top
  import eic_pkg::*;
#(
  parameter int SRC4_N = 4,
  parameter int SRC5_N = 4,
  parameter int SRC6_N = 4
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  // Avalon-MM slave
  input  wire logic [9:0]              avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [31:0]             avs_readdata_out,
  output logic                         avs_waitrequest_out,
  // Pins
  input  wire logic [EIC_USR_PINS-1:0] user_io_pins_in,
  input  wire logic                    ext_irq_pin_two_in,
  input  wire logic                    ext_irq_pin_three_in,
  // Peripheral request sources
  input  wire logic [SRC4_N-1:0]       smartcard_src_in,
  input  wire logic [SRC5_N-1:0]       usb_rtc_keypad_src_in,
  input  wire logic [SRC6_N-1:0]       i2c_fault_cmp_src_in,
  input  wire logic                    serial1_req_in,
  // CPU interrupt sequencer
  input  wire logic [EIC_LINES-1:0]    service_ack_in,
  output logic      [EIC_LINES-1:0]    irq_req_out,
  output logic                         serial1_irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           timer_and_ext_request_control;
    logic [7:0]           ien0;
    logic [7:0]           ien1;
    logic [7:0]           serial1_interrupt_enable;
    logic [7:0]           ext_request_flags;
    logic [7:0]           ext_edge_select;
    logic [7:0]           upol;
    logic [7:0]           uprio;
    logic [7:0]           uen;
    logic [7:0]           u_s1;
    logic [7:0]           u_s2;
    logic [1:0]           l01_prev;
    logic                 p2_s1;
    logic                 p2_s2;
    logic                 p2_prev;
    logic                 p3_s1;
    logic                 p3_s2;
    logic                 p3_prev;
    logic                 ack;
    logic [7:0]           rdata;
    logic [7:0]           rd_idx;
    logic [EIC_LINES-1:0] req;
    logic                 ser1;
  } eic_state_s;

  eic_state_s st_q;
  eic_state_s st_d;

  eic_src_if b4_if ();
  eic_src_if b5_if ();
  eic_src_if b6_if ();

  logic [7:0]           idx;
  logic                 hit_ok;
  logic                 req_new;
  logic                 wr_now;
  logic                 rd_now;
  logic [7:0]           wd;
  logic [7:0]           rmux;
  logic [7:0]           usr_act;
  logic [1:0]           line_n;
  logic [1:0]           fall01;
  logic                 ev2;
  logic                 ev3;
  logic [EIC_LINES-1:0] en_vec;
  logic [EIC_LINES-1:0] flag_vec;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle so read data can come from a flop
  assign idx     = avs_address_in[9:2];
  assign hit_ok  = (avs_address_in[1:0] == 2'b00);
  assign req_new = (avs_read_in | avs_write_in) & ~st_q.ack;
  assign wr_now  = avs_write_in & st_q.ack & avs_byteenable_in[0] & hit_ok;
  assign rd_now  = avs_read_in & st_q.ack;
  assign wd      = avs_writedata_in[7:0];
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st_q.ack;
  assign avs_readdata_out    = {24'h000000, st_q.rdata};

  // Read multiplexer; unmapped or misaligned addresses read zero
  always_comb begin
    rmux = 8'h00;
    if (hit_ok) begin
      unique case (idx)
        EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL: rmux = st_q.timer_and_ext_request_control;
        EIC_IDX_SER1_EN:   rmux = st_q.serial1_interrupt_enable;
        EIC_IDX_EN_MAIN:   rmux = st_q.ien0;
        EIC_IDX_EN_EXT:    rmux = st_q.ien1;
        EIC_IDX_REQ_FLAGS: rmux = st_q.ext_request_flags & EIC_WM_REQ_FLAGS;
        EIC_IDX_EDGE_SEL:  rmux = st_q.ext_edge_select;
        EIC_IDX_USR_POL:   rmux = st_q.upol;
        EIC_IDX_USR_PRIO:  rmux = st_q.uprio;
        EIC_IDX_USR_EN:    rmux = st_q.uen;
        EIC_IDX_SRC4_MASK: rmux = b4_if.mask;
        EIC_IDX_SRC4_FLAG: rmux = b4_if.flags;
        EIC_IDX_SRC5_MASK: rmux = b5_if.mask;
        EIC_IDX_SRC5_FLAG: rmux = b5_if.flags;
        EIC_IDX_SRC6_MASK: rmux = b6_if.mask;
        EIC_IDX_SRC6_FLAG: rmux = b6_if.flags;
        default:           rmux = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bank control
  // ----------------------------------------------------------------
  // Clear only what the read returned, so a source arriving mid-read survives
  assign b4_if.mask_we    = wr_now & (idx == EIC_IDX_SRC4_MASK);
  assign b5_if.mask_we    = wr_now & (idx == EIC_IDX_SRC5_MASK);
  assign b6_if.mask_we    = wr_now & (idx == EIC_IDX_SRC6_MASK);
  assign b4_if.wdata      = wd;
  assign b5_if.wdata      = wd;
  assign b6_if.wdata      = wd;
  assign b4_if.rd_clear   = rd_now & (st_q.rd_idx == EIC_IDX_SRC4_FLAG);
  assign b5_if.rd_clear   = rd_now & (st_q.rd_idx == EIC_IDX_SRC5_FLAG);
  assign b6_if.rd_clear   = rd_now & (st_q.rd_idx == EIC_IDX_SRC6_FLAG);
  assign b4_if.clear_bits = st_q.rdata;
  assign b5_if.clear_bits = st_q.rdata;
  assign b6_if.clear_bits = st_q.rdata;

  // ----------------------------------------------------------------
  // Request detection
  // ----------------------------------------------------------------
  // User pins: a polarity bit of 1 means the pin is active high
  always_comb begin
    usr_act   = ~(st_q.u_s2 ^ st_q.upol) & st_q.uen;
    line_n[0] = ~|(usr_act & st_q.uprio);
    line_n[1] = ~|(usr_act & ~st_q.uprio);
    fall01    = st_q.l01_prev & ~line_n;
    ev2 = st_q.ext_edge_select[EIC_POL2_B] ? (st_q.p2_s2 & ~st_q.p2_prev)
                                 : (~st_q.p2_s2 & st_q.p2_prev);
    ev3 = st_q.ext_edge_select[EIC_POL3_B] ? (st_q.p3_s2 & ~st_q.p3_prev)
                                 : (~st_q.p3_s2 & st_q.p3_prev);
  end

  // Enables and flags as one vector per line
  assign en_vec   = {st_q.ien1[5:1], st_q.ien0[EIC_EN1_B], st_q.ien0[EIC_EN0_B]};
  assign flag_vec = {st_q.ext_request_flags[5:1], st_q.timer_and_ext_request_control[EIC_TC_FLAG1], st_q.timer_and_ext_request_control[EIC_TC_FLAG0]};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Two-flop synchronisers; first stage feeds only the second
    st_d.u_s1     = user_io_pins_in;
    st_d.u_s2     = st_q.u_s1;
    st_d.p2_s1    = ext_irq_pin_two_in;
    st_d.p2_s2    = st_q.p2_s1;
    st_d.p3_s1    = ext_irq_pin_three_in;
    st_d.p3_s2    = st_q.p3_s1;
    st_d.l01_prev = line_n;
    st_d.p2_prev  = st_q.p2_s2;
    st_d.p3_prev  = st_q.p3_s2;

    // Bus handshake: capture read data on the first edge, finish on the next
    st_d.ack = req_new;
    if (req_new) begin
      st_d.rdata  = rmux;
      st_d.rd_idx = hit_ok ? idx : 8'h00;
    end

    // Software writes
    if (wr_now) begin
      unique case (idx)
        EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL: st_d.timer_and_ext_request_control  = wd;
        EIC_IDX_SER1_EN:   st_d.serial1_interrupt_enable  = wd & EIC_WM_SER1_EN;
        EIC_IDX_EN_MAIN:   st_d.ien0  = wd & EIC_WM_EN_MAIN;
        EIC_IDX_EN_EXT:    st_d.ien1  = wd & EIC_WM_EN_EXT;
        EIC_IDX_REQ_FLAGS: st_d.ext_request_flags = wd & EIC_WM_REQ_FLAGS;
        EIC_IDX_EDGE_SEL:  st_d.ext_edge_select = wd & EIC_WM_EDGE_SEL;
        EIC_IDX_USR_POL:   st_d.upol  = wd;
        EIC_IDX_USR_PRIO:  st_d.uprio = wd;
        EIC_IDX_USR_EN:    st_d.uen   = wd;
        default:           st_d.timer_and_ext_request_control  = st_d.timer_and_ext_request_control;
      endcase
    end

    // Service start clears the flag; a new event in the same cycle wins
    if (service_ack_in[0]) st_d.timer_and_ext_request_control[EIC_TC_FLAG0] = 1'b0;
    if (service_ack_in[1]) st_d.timer_and_ext_request_control[EIC_TC_FLAG1] = 1'b0;
    st_d.ext_request_flags[5:1] = st_d.ext_request_flags[5:1] & ~service_ack_in[6:2];

    // Lines 0/1: edge mode latches, level mode follows the pin
    if (st_d.timer_and_ext_request_control[EIC_TC_TYPE0]) begin
      st_d.timer_and_ext_request_control[EIC_TC_FLAG0] = st_d.timer_and_ext_request_control[EIC_TC_FLAG0] | fall01[0];
    end else begin
      st_d.timer_and_ext_request_control[EIC_TC_FLAG0] = ~line_n[0];
    end
    if (st_d.timer_and_ext_request_control[EIC_TC_TYPE1]) begin
      st_d.timer_and_ext_request_control[EIC_TC_FLAG1] = st_d.timer_and_ext_request_control[EIC_TC_FLAG1] | fall01[1];
    end else begin
      st_d.timer_and_ext_request_control[EIC_TC_FLAG1] = ~line_n[1];
    end

    // Lines 2..6 are set whether enabled or not
    st_d.ext_request_flags[1] = st_d.ext_request_flags[1] | ev2;
    st_d.ext_request_flags[2] = st_d.ext_request_flags[2] | ev3;
    st_d.ext_request_flags[3] = st_d.ext_request_flags[3] | b4_if.line_evt;
    st_d.ext_request_flags[4] = st_d.ext_request_flags[4] | b5_if.line_evt;
    st_d.ext_request_flags[5] = st_d.ext_request_flags[5] | b6_if.line_evt;

    // Gate requests toward the CPU
    st_d.req  = flag_vec & en_vec & {EIC_LINES{st_q.ien0[EIC_GLOBAL_B]}};
    st_d.ser1 = serial1_req_in & st_q.serial1_interrupt_enable[EIC_SER1_EN_B]
                & st_q.ien0[EIC_GLOBAL_B];
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign irq_req_out     = st_q.req;
  assign serial1_irq_out = st_q.ser1;

  // ----------------------------------------------------------------
  // Multi-source banks
  // ----------------------------------------------------------------
  eic_src_bank #(.SRC_N(SRC4_N)) u_bank4 (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .src_in   (smartcard_src_in),
    .bus      (b4_if.bank)
  );
  eic_src_bank #(.SRC_N(SRC5_N)) u_bank5 (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .src_in   (usb_rtc_keypad_src_in),
    .bus      (b5_if.bank)
  );
  eic_src_bank #(.SRC_N(SRC6_N)) u_bank6 (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .src_in   (i2c_fault_cmp_src_in),
    .bus      (b6_if.bank)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ser1_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    serial1_irq_out |-> $past(st_q.serial1_interrupt_enable[0] && serial1_req_in))
    else $error("serial 1 request passed while disabled");

  chk_fall_sets: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_q.timer_and_ext_request_control[0] && st_q.l01_prev[0] && !line_n[0] && !wr_now) |=> st_q.timer_and_ext_request_control[1])
    else $error("falling edge on line 0 did not set its flag");

  chk_level_mode: assert property (@(posedge clk_in) disable iff (reset_in)
    (!st_q.timer_and_ext_request_control[2] && !wr_now) |=> (st_q.timer_and_ext_request_control[3] == !$past(line_n[1])))
    else $error("level mode flag does not follow line 1");

  chk_pol_three: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_q.ext_edge_select[6] && st_q.p3_s2 && !st_q.p3_prev && !wr_now) |=> st_q.ext_request_flags[2])
    else $error("rising edge on line 3 missed");

  chk_pol_two: assert property (@(posedge clk_in) disable iff (reset_in)
    (!st_q.ext_edge_select[5] && !st_q.p2_s2 && st_q.p2_prev && !wr_now) |=> st_q.ext_request_flags[1])
    else $error("falling edge on line 2 missed");

  chk_unused_bits: assert property (@(posedge clk_in) disable iff (reset_in)
    (rd_now && st_q.rd_idx == EIC_IDX_REQ_FLAGS) |-> (st_q.rdata & 8'hc1) == 8'h00)
    else $error("unused request flag bits read nonzero");

  chk_enable_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    (irq_req_out & ~$past(en_vec & {EIC_LINES{st_q.ien0[7]}})) == '0)
    else $error("request reached the CPU while disabled");

  chk_auto_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    (service_ack_in[3] && !ev3 && !wr_now) |=> !st_q.ext_request_flags[2])
    else $error("line 3 flag not cleared at service");

endmodule : eic_top

// *** verif/eic_cpu_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Interrupt sequencer stand-in: starts service of any raised line
// ----------------------------------------------------------------
module eic_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [6:0] irq_req_in,
  input  wire logic       slow_in,
  output logic      [6:0] service_ack_out
);
  logic [6:0] busy_q;
  logic [2:0] wait_q;

  // One ack per request; busy blocks a second ack while the request drains
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      service_ack_out <= '0;
      busy_q          <= '0;
      wait_q          <= '0;
    end else begin
      service_ack_out <= '0;
      wait_q          <= (|(irq_req_in & ~busy_q)) ? wait_q + 3'd1 : 3'd0;
      for (int k = 0; k < 7; k++) begin
        if (!irq_req_in[k]) begin
          busy_q[k] <= 1'b0;
        end else if (!busy_q[k] && (!slow_in || wait_q == 3'd3)) begin
          service_ack_out[k] <= 1'b1;
          busy_q[k]          <= 1'b1;
        end
      end
    end
  end
endmodule // eic_cpu_model

// *** verif/eic_top_test.sv ***
`timescale 1ns/1ps
module eic_top_test;
  import eic_pkg::*;
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic [9:0]  adr      = '0;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdat     = '0;
  logic [31:0] rdata;
  logic [31:0] rdat;
  logic        wreq;
  logic [3:0]  be       = 4'h1;
  logic [7:0]  user_io_pins      = 8'hff;
  logic        p2       = 1'b1;
  logic        p3       = 1'b0;
  logic        s1       = 1'b0;
  logic        slow     = 1'b1;
  logic [3:0]  src [3]  = '{default: 4'h0};
  logic [6:0]  ack;
  logic [6:0]  irq;
  logic        s1_irq;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;

  eic_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .user_io_pins_in(user_io_pins), .ext_irq_pin_two_in(p2), .ext_irq_pin_three_in(p3),
    .smartcard_src_in(src[0]), .usb_rtc_keypad_src_in(src[1]),
    .i2c_fault_cmp_src_in(src[2]), .serial1_req_in(s1), .service_ack_in(ack),
    .irq_req_out(irq), .serial1_irq_out(s1_irq));

  eic_cpu_model i_cpu (.clk_in(clk_in), .reset_in(reset_in), .irq_req_in(irq),
    .slow_in(slow), .service_ack_out(ack));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // A hang in a bus wait ends here rather than running forever
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waitrequest and read data are sampled at the rising edge, before the design updates
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    rd   <= !w;
    wr   <= w;
    do @(posedge clk_in); while (wreq !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rdat, {24'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] exp_fl;
    exp_fl = 8'h00;
    tick(10);
    @(posedge clk_in);
    reset_in <= 1'b0;
    // Reset values, unmapped index, writable masks
    rc(EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h00);
    rc(EIC_IDX_REQ_FLAGS, 8'h00);
    rc(8'h10, 8'h00);
    // A write with byte lane 0 disabled must be ignored
    be <= 4'h0;
    bus(1'b1, EIC_IDX_EDGE_SEL, 8'hff);
    be <= 4'h1;
    rc(EIC_IDX_EDGE_SEL, 8'h00);
    bus(1'b1, EIC_IDX_EDGE_SEL, 8'hff);
    rc(EIC_IDX_EDGE_SEL, 8'h60);
    bus(1'b1, EIC_IDX_REQ_FLAGS, 8'hff);
    rc(EIC_IDX_REQ_FLAGS, 8'h3e);
    bus(1'b1, EIC_IDX_REQ_FLAGS, 8'h00);
    $display("test registers done");
    // Serial channel 1 gating by its enable and the global enable
    s1 <= 1'b1;
    bus(1'b1, EIC_IDX_SER1_EN, 8'hff);
    rc(EIC_IDX_SER1_EN, 8'h01);
    bus(1'b1, EIC_IDX_EN_MAIN, 8'h80);
    tick(2);
    check(s1_irq, 1'b1);
    bus(1'b1, EIC_IDX_EN_MAIN, 8'h00);
    tick(2);
    check(s1_irq, 1'b0);
    bus(1'b1, EIC_IDX_EN_MAIN, 8'h80);
    bus(1'b1, EIC_IDX_SER1_EN, 8'h00);
    tick(2);
    check(s1_irq, 1'b0);
    $display("test serial1 done");
    // Dedicated pins: line 2 falling, line 3 rising, flagged while disabled
    bus(1'b1, EIC_IDX_EDGE_SEL, 8'h40);
    p2 <= 1'b0;
    p3 <= 1'b1;
    tick(8);
    check(irq, 7'h00);
    rc(EIC_IDX_REQ_FLAGS, 8'h06);
    bus(1'b1, EIC_IDX_EN_EXT, 8'h06);
    tick(2);
    check(irq, 7'h0c);
    tick(10);
    rc(EIC_IDX_REQ_FLAGS, 8'h00);
    // Opposite polarities: line 2 rising, line 3 falling, lines disabled
    bus(1'b1, EIC_IDX_EN_EXT, 8'h00);
    bus(1'b1, EIC_IDX_EDGE_SEL, 8'h20);
    p2 <= 1'b1;
    p3 <= 1'b0;
    tick(8);
    rc(EIC_IDX_REQ_FLAGS, 8'h06);
    bus(1'b1, EIC_IDX_REQ_FLAGS, 8'h00);
    $display("test dedicated pins done");
    // User pins: pin 0 edge to line 0, pin 1 level to line 1, active low
    slow <= 1'b0;
    bus(1'b1, EIC_IDX_USR_PRIO, 8'h01);
    bus(1'b1, EIC_IDX_USR_EN, 8'h03);
    bus(1'b1, EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h01);
    user_io_pins <= 8'hfe;
    tick(8);
    rc(EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h03);
    user_io_pins <= 8'hfd;
    tick(8);
    rc(EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h0b);
    bus(1'b1, EIC_IDX_EN_MAIN, 8'h81);
    tick(8);
    rc(EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h09);
    user_io_pins <= 8'hff;
    tick(8);
    rc(EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h01);
    // Swapped modes: line 1 edge latched, line 0 level follows pin despite service
    bus(1'b1, EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h04);
    user_io_pins <= 8'hfd;
    tick(8);
    rc(EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h0c);
    user_io_pins <= 8'hfe;
    tick(8);
    rc(EIC_IDX_TIMER_AND_EXT_REQUEST_CONTROL_CTRL, 8'h0e);
    user_io_pins <= 8'hff;
    $display("test user pins done");
    // Peripheral banks: masked sources, read-clear, held level makes no new edge
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 8'(EIC_IDX_SRC4_MASK + 2 * k), 8'h03);
      src[k] <= 4'h3;
      tick(8);
      exp_fl = exp_fl | (8'h08 << k);
      rc(8'(EIC_IDX_SRC4_FLAG + 2 * k), 8'h03);
      rc(EIC_IDX_REQ_FLAGS, exp_fl);
      rc(8'(EIC_IDX_SRC4_FLAG + 2 * k), 8'h00);
    end
    bus(1'b1, EIC_IDX_EN_EXT, 8'h7e);
    tick(8);
    rc(EIC_IDX_REQ_FLAGS, 8'h00);
    $display("test peripheral banks done");
    final_report();
  end
endmodule // eic_top_test
